// ==== hdl/nco_pkg.sv ====
// Shared constants for the oscillator retuning link, host and device ends
package nco_pkg;

	// =========================================================
	// Frame layout
	localparam int FRAME_BITS = 24;
	localparam int INSTR_BITS = 8;
	localparam int DATA_BITS = 16;
	localparam logic [4:0] INSTR_LAST = 5'h07;
	localparam logic [4:0] DATA_LAST = 5'h17;
	localparam logic [4:0] FRAME_DONE = 5'h18;
	localparam int READ_BIT = 7;

	// =========================================================
	// Device register map, 7-bit serial addresses
	localparam logic [6:0] ADDR_PAGE = 7'h00;
	localparam logic [6:0] ADDR_FREQ_LO = 7'h10;
	localparam logic [6:0] ADDR_FREQ_MID = 7'h11;
	localparam logic [6:0] ADDR_FREQ_HI = 7'h12;
	localparam logic [6:0] ADDR_PHASE = 7'h13;
	localparam logic [15:0] PAGE_RESET = 16'h0000;
	localparam logic [47:0] FREQ_RESET = 48'h000000000000;
	localparam logic [15:0] PHASE_RESET = 16'h0000;

	// =========================================================
	// Channels
	localparam int NUM_CHAN = 2;
	localparam int FREQ_W = 48;
	localparam int PHASE_W = 16;

	// =========================================================
	// Timing
	localparam int SYS_CLK_HZ = 10_000_000;
	localparam int SCLK_MAX_HZ = 10_000_000;
	localparam int SCLK_HZ = 1_250_000;
	localparam int SCLK_HALF_CYC = SYS_CLK_HZ / (2 * SCLK_HZ);
	localparam int SYS_CLK_PS = 1_000_000_000 / (SYS_CLK_HZ / 1000);
	localparam int SYNC_LAT_NS = 160;
	localparam int SYNC_LAT_CYC_RAW = (SYNC_LAT_NS * 1000) / SYS_CLK_PS;
	localparam logic [3:0] SYNC_LAT_CYC = (SYNC_LAT_CYC_RAW < 1) ? 4'h1 : 4'(SYNC_LAT_CYC_RAW);
	localparam int SYSREF_PULSE_CYC = 4;

	// =========================================================
	// Host Avalon register map, byte addresses
	localparam logic [4:0] HOST_DATA = 5'h00;
	localparam logic [4:0] HOST_CMD = 5'h04;
	localparam logic [4:0] HOST_SYSREF = 5'h08;
	localparam logic [4:0] HOST_STATUS = 5'h0c;
	localparam logic [4:0] HOST_RDATA = 5'h10;
	localparam int STAT_BUSY = 0;
	localparam int STAT_SYSREF = 1;

endpackage

// ==== hdl/nco_link_if.sv ====
// Serial register link plus sync pulse between host and device
`timescale 1ns/100ps
interface nco_link_if;
	logic sclk;
	logic csN;
	logic mosi;
	logic miso;
	logic sysref;
	modport host (output sclk, output csN, output mosi, output sysref, input miso);
	modport device (input sclk, input csN, input mosi, input sysref, output miso);
endinterface

// ==== hdl/nco_device.sv ====
// Device end: serial register slave, pending words, synced oscillators
`timescale 1ns/100ps
module nco_device (
	// Oscillator sample clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// Serial link and sync pulse
	nco_link_if.device link,
	// Per-channel oscillator phase outputs
	output logic [15:0] channelAOutput,
	output logic [15:0] channelBOutput,
	// One-cycle pulse when pending words take effect
	output logic syncApplied
);

	// =========================================================
	// Link clock domain: frame capture

	logic [4:0] bitCnt;
	logic [22:0] shiftIn;
	logic [7:0] instr;
	logic [15:0] readShift;
	logic [15:0] readVal;
	logic [7:0] next_instr;
	logic [15:0] wrData;
	logic chan;
	logic chanOk;

	// Pending register set, written over the link
	logic [15:0] pageSel;
	logic [47:0] freqPend [nco_pkg::NUM_CHAN];
	logic [15:0] phasePend [nco_pkg::NUM_CHAN];

	// Instruction and data as seen at the current edge
	assign next_instr = {shiftIn[6:0], link.mosi};
	assign wrData = {shiftIn[14:0], link.mosi};

	// Page picks the channel register set
	assign chan = pageSel[0];
	assign chanOk = (pageSel < 16'(nco_pkg::NUM_CHAN));

	// Read-back value for the addressed register
	always_comb begin
		readVal = 16'h0000;
		unique case (next_instr[6:0])
			nco_pkg::ADDR_PAGE: readVal = pageSel;
			nco_pkg::ADDR_FREQ_LO: readVal = chanOk ? freqPend[chan][15:0] : 16'h0000;
			nco_pkg::ADDR_FREQ_MID: readVal = chanOk ? freqPend[chan][31:16] : 16'h0000;
			nco_pkg::ADDR_FREQ_HI: readVal = chanOk ? freqPend[chan][47:32] : 16'h0000;
			nco_pkg::ADDR_PHASE: readVal = chanOk ? phasePend[chan] : 16'h0000;
			default: readVal = 16'h0000;
		endcase
	end

	// Bit counter and shifters, cleared while the frame is idle
	always_ff @(posedge link.sclk or negedge resetn or posedge link.csN) begin
		if (!resetn || link.csN) begin
			bitCnt <= 5'h00;
			shiftIn <= 23'h000000;
			instr <= 8'h00;
			readShift <= 16'h0000;
		end else begin
			shiftIn <= {shiftIn[21:0], link.mosi};
			if (bitCnt != nco_pkg::FRAME_DONE) begin
				bitCnt <= bitCnt + 5'h01;
			end
			if (bitCnt == nco_pkg::INSTR_LAST) begin
				instr <= next_instr;
				// Read data leaves MSB first from the next edge on
				readShift <= next_instr[nco_pkg::READ_BIT] ? readVal : 16'h0000;
			end else begin
				readShift <= {readShift[14:0], 1'b0};
			end
		end
	end

	// Serial read data from a flip-flop
	assign link.miso = readShift[15];

	// Register writes on the last data bit of a write frame
	always_ff @(posedge link.sclk or negedge resetn) begin
		if (!resetn) begin
			pageSel <= nco_pkg::PAGE_RESET;
			for (int c = 0; c < nco_pkg::NUM_CHAN; c++) begin
				freqPend[c] <= nco_pkg::FREQ_RESET;
				phasePend[c] <= nco_pkg::PHASE_RESET;
			end
		end else if (!link.csN && bitCnt == nco_pkg::DATA_LAST && !instr[nco_pkg::READ_BIT]) begin
			unique case (instr[6:0])
				nco_pkg::ADDR_PAGE: pageSel <= wrData;
				nco_pkg::ADDR_FREQ_LO: begin
					if (chanOk) begin
						freqPend[chan][15:0] <= wrData;
					end
				end
				nco_pkg::ADDR_FREQ_MID: begin
					if (chanOk) begin
						freqPend[chan][31:16] <= wrData;
					end
				end
				nco_pkg::ADDR_FREQ_HI: begin
					if (chanOk) begin
						freqPend[chan][47:32] <= wrData;
					end
				end
				nco_pkg::ADDR_PHASE: begin
					if (chanOk) begin
						phasePend[chan] <= wrData;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// =========================================================
	// Sample clock domain: sync pulse detection

	logic [2:0] sysrefSync;
	logic sysrefLevel;
	logic [2:0] csSync;
	logic csIdle;
	logic [3:0] latCnt;
	logic apply;

	// Three-stage synchronisers for the sysref and csN pin inputs
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			sysrefSync <= 3'h0;
			csSync <= 3'h7;
		end else begin
			sysrefSync <= {sysrefSync[1:0], link.sysref};
			csSync <= {csSync[1:0], link.csN};
		end
	end

	// Accept a new level once stages two and three agree
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			sysrefLevel <= 1'b0;
			csIdle <= 1'b1;
		end else begin
			if (sysrefSync[1] == sysrefSync[2]) begin
				sysrefLevel <= sysrefSync[2];
			end
			if (csSync[1] == csSync[2]) begin
				csIdle <= csSync[2];
			end
		end
	end

	// Rising sync edge while no frame runs starts the latency count
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			latCnt <= 4'h0;
		end else if (sysrefSync[1] == sysrefSync[2] && sysrefSync[2] && !sysrefLevel && csIdle) begin
			latCnt <= nco_pkg::SYNC_LAT_CYC;
		end else if (latCnt != 4'h0) begin
			latCnt <= latCnt - 4'h1;
		end
	end

	assign apply = (latCnt == 4'h1);

	// =========================================================
	// Oscillators, one per channel

	logic [47:0] freqAct [nco_pkg::NUM_CHAN];
	logic [15:0] phaseAct [nco_pkg::NUM_CHAN];
	logic [47:0] acc [nco_pkg::NUM_CHAN];

	// Pending words are stable while the link is idle; take them on apply
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			for (int c = 0; c < nco_pkg::NUM_CHAN; c++) begin
				freqAct[c] <= nco_pkg::FREQ_RESET;
				phaseAct[c] <= nco_pkg::PHASE_RESET;
			end
		end else if (apply) begin
			for (int c = 0; c < nco_pkg::NUM_CHAN; c++) begin
				freqAct[c] <= freqPend[c];
				phaseAct[c] <= phasePend[c];
			end
		end
	end

	// Phase accumulators, cleared together on apply for alignment
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			for (int c = 0; c < nco_pkg::NUM_CHAN; c++) begin
				acc[c] <= 48'h000000000000;
			end
		end else begin
			for (int c = 0; c < nco_pkg::NUM_CHAN; c++) begin
				if (apply) begin
					acc[c] <= 48'h000000000000;
				end else begin
					acc[c] <= acc[c] + freqAct[c];
				end
			end
		end
	end

	// Output phase is accumulator top plus the phase offset
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			channelAOutput <= 16'h0000;
			channelBOutput <= 16'h0000;
			syncApplied <= 1'b0;
		end else begin
			channelAOutput <= acc[0][47:32] + phaseAct[0];
			channelBOutput <= acc[1][47:32] + phaseAct[1];
			syncApplied <= apply;
		end
	end

endmodule

// ==== hdl/nco_host.sv ====
// Host end: Avalon-MM command registers, serial master, sync pulse
`timescale 1ns/100ps
module nco_host (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// Avalon-MM slave
	input wire logic [4:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	// Serial link and sync pulse
	nco_link_if.host link
);

	typedef enum logic [1:0] {S_IDLE, S_SHIFT, S_END} state_t;

	state_t state;
	logic [15:0] dataReg;
	logic [7:0] cmdReg;
	logic [15:0] rdataReg;
	logic [23:0] frame;
	logic [15:0] inShift;
	logic [4:0] bitCnt;
	logic [2:0] halfCnt;
	logic sclk;
	logic csN;
	logic mosi;
	logic sysref;
	logic [2:0] sysrefCnt;
	logic [2:0] misoSync;
	logic misoStable;
	logic busy;
	logic stall;
	logic accept;

	// =========================================================
	// Bus slave
	assign busy = (state != S_IDLE) || sysref;
	assign stall = write && busy && (address == nco_pkg::HOST_CMD || address == nco_pkg::HOST_SYSREF);
	assign accept = (read || write) && !waitrequest;

	// Waitrequest drops for one cycle once a request may complete
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			waitrequest <= 1'b1;
		end else begin
			waitrequest <= !((read || write) && waitrequest && !stall);
		end
	end

	// Read data registered together with the waitrequest drop
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			readdata <= 32'h00000000;
		end else if (read && waitrequest) begin
			unique case (address)
				nco_pkg::HOST_DATA: readdata <= {16'h0000, dataReg};
				nco_pkg::HOST_CMD: readdata <= {24'h000000, cmdReg};
				nco_pkg::HOST_STATUS: readdata <= {30'h00000000, sysref, state != S_IDLE};
				nco_pkg::HOST_RDATA: readdata <= {16'h0000, rdataReg};
				default: readdata <= 32'h00000000;
			endcase
		end
	end

	// Data word for the next frame and the last command word
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			dataReg <= 16'h0000;
			cmdReg <= 8'h00;
		end else if (accept && write) begin
			if (address == nco_pkg::HOST_DATA) begin
				dataReg <= writedata[15:0];
			end
			if (address == nco_pkg::HOST_CMD) begin
				cmdReg <= writedata[7:0];
			end
		end
	end

	// =========================================================
	// Serial read data synchroniser
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			misoSync <= 3'h0;
			misoStable <= 1'b0;
		end else begin
			misoSync <= {misoSync[1:0], link.miso};
			if (misoSync[1] == misoSync[2]) begin
				misoStable <= misoSync[2];
			end
		end
	end

	// =========================================================
	// Serial master, clock divided from clk_sys
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state <= S_IDLE;
			frame <= 24'h000000;
			inShift <= 16'h0000;
			rdataReg <= 16'h0000;
			bitCnt <= 5'h00;
			halfCnt <= 3'h0;
			sclk <= 1'b0;
			csN <= 1'b1;
			mosi <= 1'b0;
		end else begin
			unique case (state)
				S_IDLE: begin
					if (accept && write && address == nco_pkg::HOST_CMD) begin
						frame <= {writedata[7:0], dataReg};
						mosi <= writedata[7];
						csN <= 1'b0;
						bitCnt <= 5'h00;
						halfCnt <= 3'h0;
						state <= S_SHIFT;
					end
				end
				S_SHIFT: begin
					if (halfCnt == 3'(nco_pkg::SCLK_HALF_CYC - 1)) begin
						halfCnt <= 3'h0;
						if (!sclk) begin
							sclk <= 1'b1;
							inShift <= {inShift[14:0], misoStable};
						end else begin
							sclk <= 1'b0;
							if (bitCnt == nco_pkg::DATA_LAST) begin
								state <= S_END;
							end else begin
								bitCnt <= bitCnt + 5'h01;
								frame <= {frame[22:0], 1'b0};
								mosi <= frame[22];
							end
						end
					end else begin
						halfCnt <= halfCnt + 3'h1;
					end
				end
				S_END: begin
					if (halfCnt == 3'(nco_pkg::SCLK_HALF_CYC - 1)) begin
						halfCnt <= 3'h0;
						csN <= 1'b1;
						if (cmdReg[nco_pkg::READ_BIT]) begin
							rdataReg <= inShift;
						end
						state <= S_IDLE;
					end else begin
						halfCnt <= halfCnt + 3'h1;
					end
				end
			endcase
		end
	end

	// =========================================================
	// Global sync pulse, one per software request
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			sysref <= 1'b0;
			sysrefCnt <= 3'h0;
		end else if (accept && write && address == nco_pkg::HOST_SYSREF) begin
			sysref <= 1'b1;
			sysrefCnt <= 3'(nco_pkg::SYSREF_PULSE_CYC - 1);
		end else if (sysrefCnt != 3'h0) begin
			sysrefCnt <= sysrefCnt - 3'h1;
		end else begin
			sysref <= 1'b0;
		end
	end

	assign link.sclk = sclk;
	assign link.csN = csN;
	assign link.mosi = mosi;
	assign link.sysref = sysref;

endmodule

// ==== sim/nco_link_chk.sv ====
// Checker for the serial link and the sync pulse between both ends
`timescale 1ns/100ps
module nco_link_chk (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// Link and sync
	input wire logic sclk,
	input wire logic csN,
	input wire logic mosi,
	input wire logic sysref,
	input wire logic syncApplied
);
	// ==========================================
	// Helpers
	logic sclkQ;
	logic [4:0] riseCnt;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	// Count serial clock rises within a frame
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			sclkQ <= 1'b0;
			riseCnt <= 5'h00;
		end else begin
			sclkQ <= sclk;
			if (csN)
				riseCnt <= 5'h00;
			else if (sclk && !sclkQ)
				riseCnt <= riseCnt + 5'h01;
		end
	end

	// ==========================================
	// Serial clock phases
	sequence highPhase;
		sclk[*4] ##1 !sclk;
	endsequence
	sequence lowPhase;
		!sclk[*4];
	endsequence

	// ==========================================
	// Assertions
	a_sclk_idle_low: assert property (csN |-> !sclk)
		else $error("serial clock active outside a frame");
	a_sclk_high_len: assert property ($rose(sclk) |-> highPhase)
		else $error("serial clock high phase too short");
	a_sclk_low_len: assert property ($fell(sclk) |-> lowPhase)
		else $error("serial clock low phase too short");
	a_frame_rise_count: assert property ($rose(csN) |-> riseCnt == 5'h18)
		else $error("frame without 24 clock rises");
	a_select_lead: assert property ($fell(csN) |-> lowPhase ##1 sclk)
		else $error("first clock rise at wrong distance");
	a_mosi_steady: assert property (sclk && $past(sclk) |-> $stable(mosi))
		else $error("data moved while serial clock high");
	a_sysref_width: assert property ($rose(sysref) |-> sysref[*4] ##1 !sysref)
		else $error("sync pulse width wrong");
	a_sysref_idle_link: assert property (sysref |-> csN)
		else $error("sync pulse during a frame");
	a_sync_delay: assert property ($rose(sysref) |-> ##[2:8] syncApplied)
		else $error("words not applied after sync pulse");
	a_sync_one_cycle: assert property (syncApplied |=> !syncApplied)
		else $error("apply pulse longer than one cycle");
endmodule

// ==== sim/nco_tuning_sync_update_tb.sv ====
// Testbench joining host and device ends over the serial link
`timescale 1ns/100ps
module nco_tuning_sync_update_tb;
	// ==========================================
	// Signals
	logic clk_sys;
	logic resetn = 1'b0;
	logic [4:0] address = 5'h00;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h00000000;
	logic [31:0] readdata;
	logic waitrequest;
	logic [15:0] channelAOutput;
	logic [15:0] channelBOutput;
	logic syncApplied;
	int n_fail = 0;
	int checks = 0;

	// ==========================================
	// Both ends and the checker
	nco_link_if link ();
	nco_host nco_host_inst (.clk_sys(clk_sys), .resetn(resetn), .address(address),
		.read(read), .write(write), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .link(link));
	nco_device nco_device_inst (.clk_sys(clk_sys), .resetn(resetn), .link(link),
		.channelAOutput(channelAOutput), .channelBOutput(channelBOutput),
		.syncApplied(syncApplied));
	nco_link_chk nco_link_chk_inst (.clk_sys(clk_sys), .resetn(resetn), .sclk(link.sclk),
		.csN(link.csN), .mosi(link.mosi), .sysref(link.sysref), .syncApplied(syncApplied));

	// Clock, 100 ns period
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	// ==========================================
	// Tasks
	task automatic finish_test();
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Avalon transfer held until waitrequest samples low
	task automatic av_xfer(input logic wr, input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int i;
		address <= a;
		writedata <= d;
		write <= wr;
		read <= !wr;
		for (i = 0; i < 2000; i++) begin
			@(posedge clk_sys);
			if (waitrequest === 1'b0)
				break;
		end
		q = readdata;
		write <= 1'b0;
		read <= 1'b0;
		if (i == 2000) begin
			n_fail++;
			finish_test();
		end
		@(posedge clk_sys);
	endtask

	task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		av_xfer(1'b1, a, d, q);
	endtask

	// Device register write as one serial frame
	task automatic dev_wr(input logic [6:0] a, input logic [15:0] d);
		wr_reg(nco_pkg::HOST_DATA, {16'h0000, d});
		wr_reg(nco_pkg::HOST_CMD, {25'h0000000, a});
	endtask

	// Device register read, compared with the expected word
	task automatic dev_chk(input logic [6:0] a, input logic [15:0] e);
		logic [31:0] q;
		int i;
		wr_reg(nco_pkg::HOST_CMD, {24'h000000, 1'b1, a});
		for (i = 0; i < 100; i++) begin
			av_xfer(1'b0, nco_pkg::HOST_STATUS, 32'h0, q);
			if (q[1:0] === 2'b00)
				break;
		end
		// Frame that never ends counts as a mismatch
		if (i == 100) begin
			n_fail++;
			finish_test();
		end
		av_xfer(1'b0, nco_pkg::HOST_RDATA, 32'h0, q);
		check(q, {16'h0000, e});
	endtask

	// Sync pulse, then wait for the apply strobe
	task automatic sync_now();
		int i;
		wr_reg(nco_pkg::HOST_SYSREF, 32'h00000000);
		for (i = 0; i < 20; i++) begin
			@(posedge clk_sys);
			if (syncApplied === 1'b1)
				break;
		end
		check({31'h0, syncApplied}, 32'h00000001);
		// Missing apply strobe ends the run
		if (i == 20)
			finish_test();
		repeat (3) @(posedge clk_sys);
	endtask

	// Per-cycle phase step of both channels
	task automatic step_chk(input logic [15:0] stepA, input logic [15:0] stepB);
		logic [15:0] a0;
		logic [15:0] b0;
		@(posedge clk_sys);
		a0 = channelAOutput;
		b0 = channelBOutput;
		@(posedge clk_sys);
		check({16'h0000, channelAOutput - a0}, {16'h0000, stepA});
		check({16'h0000, channelBOutput - b0}, {16'h0000, stepB});
	endtask

	// ==========================================
	// Main sequence
	initial begin
		logic [31:0] q;
		repeat (8) @(posedge clk_sys);
		resetn <= 1'b1;
		@(posedge clk_sys);
		av_xfer(1'b0, 5'h14, 32'h0, q);
		check(q, 32'h00000000);
		dev_chk(nco_pkg::ADDR_FREQ_HI, 16'h0000);
		dev_wr(nco_pkg::ADDR_PAGE, 16'h0000);
		dev_wr(nco_pkg::ADDR_FREQ_LO, 16'h5a5a);
		dev_wr(nco_pkg::ADDR_FREQ_HI, 16'h0001);
		dev_wr(nco_pkg::ADDR_FREQ_MID, 16'h0000);
		dev_wr(nco_pkg::ADDR_PHASE, 16'h1000);
		dev_chk(nco_pkg::ADDR_FREQ_LO, 16'h5a5a);
		dev_chk(nco_pkg::ADDR_FREQ_MID, 16'h0000);
		dev_chk(nco_pkg::ADDR_FREQ_HI, 16'h0001);
		dev_chk(nco_pkg::ADDR_PHASE, 16'h1000);
		step_chk(16'h0000, 16'h0000);
		check({16'h0000, channelAOutput}, 32'h00000000);
		dev_wr(nco_pkg::ADDR_PAGE, 16'h0001);
		dev_wr(nco_pkg::ADDR_PHASE, 16'h4000);
		dev_chk(nco_pkg::ADDR_PAGE, 16'h0001);
		dev_chk(nco_pkg::ADDR_FREQ_LO, 16'h0000);
		sync_now();
		step_chk(16'h0001, 16'h0000);
		check({16'h0000, channelBOutput}, 32'h00004000);
		dev_wr(nco_pkg::ADDR_FREQ_HI, 16'h0002);
		step_chk(16'h0001, 16'h0000);
		sync_now();
		step_chk(16'h0001, 16'h0002);
		dev_wr(nco_pkg::ADDR_PAGE, 16'h0002);
		dev_wr(nco_pkg::ADDR_FREQ_HI, 16'h7777);
		dev_chk(nco_pkg::ADDR_FREQ_HI, 16'h0000);
		finish_test();
	end
endmodule
